// ---- common/cbs_pkg.sv ----
package cbs_pkg;
  localparam logic [15:0] CBS_DUMMY_ADDR = 16'hFFFF;
  localparam logic [7:0] CBS_ZERO_BYTE = 8'h00;
  localparam logic [2:0] CBS_CNT_W1 = 3'h1;
  localparam logic [2:0] CBS_CYC_IDLE = 3'h0;
  // bus cycle positions inside one instruction, also used as cycle counts
  localparam logic [2:0] CBS_STEP2 = 3'h2;
  localparam logic [2:0] CBS_STEP3 = 3'h3;
  localparam logic [2:0] CBS_STEP4 = 3'h4;
  localparam logic [2:0] CBS_STEP5 = 3'h5;
  localparam logic [2:0] CBS_STEP6 = 3'h6;
  localparam logic [2:0] CBS_STEP7 = 3'h7;
  // byte offsets from a base address
  localparam logic [15:0] CBS_ADDR_NEXT = 16'h0001;
  localparam logic [15:0] CBS_ADDR_SKIP2 = 16'h0002;

  // instruction groups sequenced by this block
  typedef enum logic [4:0] {
    CBS_OP_NONE,
    CBS_OP_LD16_DIR,
    CBS_OP_LD16_IDX,
    CBS_OP_LD16_EXT,
    CBS_OP_ST16_DIR,
    CBS_OP_ST16_IDX,
    CBS_OP_ST16_EXT,
    CBS_OP_JSR_DIR,
    CBS_OP_JSR_IDX,
    CBS_OP_JSR_EXT,
    CBS_OP_JMP_IDX,
    CBS_OP_TIM_DIR,
    CBS_OP_TIM_IDX,
    CBS_OP_LOGIC_DIR,
    CBS_OP_LOGIC_IDX,
    CBS_OP_RMW_IDX,
    CBS_OP_RMW_EXT,
    CBS_OP_ZERO_IDX,
    CBS_OP_ZERO_EXT,
    CBS_OP_POP_X,
    CBS_OP_PUSH_ACC,
    CBS_OP_DAA_SWAP_DOUBLE_WITH_INDEX
  } cbs_op_t;

  // address source of one bus cycle
  typedef enum logic [2:0] {
    CBS_AS_PC,
    CBS_AS_DUMMY,
    CBS_AS_EA,
    CBS_AS_EA1,
    CBS_AS_SP,
    CBS_AS_SPM1,
    CBS_AS_SPP1,
    CBS_AS_SPP2
  } cbs_asrc_t;

  // what moves on the data bus in a write
  typedef enum logic [2:0] {
    CBS_WD_NONE,
    CBS_WD_HI,
    CBS_WD_LO,
    CBS_WD_RES,
    CBS_WD_ZERO,
    CBS_WD_RET_LO,
    CBS_WD_RET_HI
  } cbs_wsrc_t;

  typedef enum logic [1:0] {
    CBS_KIND_READ,
    CBS_KIND_WRITE,
    CBS_KIND_DUMMY
  } cbs_kind_t;

  // register values supplied by the core datapath
  typedef struct packed {
    logic [15:0] pc_next;
    logic [15:0] eff_addr;
    logic [15:0] stack_ptr;
    logic [15:0] ret_addr;
    logic [15:0] wdata16;
    logic [7:0] result;
  } cbs_ctx_t;

  // one bus cycle as driven on the pins
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic data_oe_n;
    logic rw;
    logic rd_n;
    logic wr_n;
    logic opcode_fetch_strobe_n;
  } cbs_bus_t;
endpackage : cbs_pkg

// ---- hw/cbs_cpu_bus_cycle_sequencer.sv ----
// Overview of operation
// RQ1 - read cycles: rw high, read low, write high
// RQ2 - write cycles: rw low, write low, data out
// RQ3 - dummy cycles: address all ones, strobes high
// RQ4 - opcode fetch strobe low only final cycle, or only cycle one for prefetching groups
// RQ5 - 16-bit loads read high then low byte
// RQ6 - 16-bit stores write high then low byte
// RQ7 - direct/indexed subroutine jump: five cycles
// RQ8 - direct test 4, logic-to-memory 6 cycles
// RQ9 - indexed jump: offset, dummy, target fetch
// RQ10 - memory read-modify-write takes six cycles
// RQ11 - clear memory: read then write zero
// RQ12 - indexed logic-to-memory 7, test 5 cycles
// RQ13 - extended subroutine jump takes six cycles
// RQ14 - pop index: prefetch, dummy, two stack reads
// RQ15 - push accumulator: read, dummy, write, fetch
// RQ16 - adjust and exchange: prefetch then dummy
// RQ17 - some instructions prefetch before internal cycles
// RQ18 - counting starts after the opcode byte
`timescale 1ns/1ps
`default_nettype none
module cbs_cpu_bus_cycle_sequencer (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire cbs_pkg::cbs_op_t i_op,
  input wire cbs_pkg::cbs_ctx_t i_ctx,
  output logic o_busy,
  output logic o_last,
  output logic [2:0] o_cycle,
  output cbs_pkg::cbs_bus_t o_bus
);
  import cbs_pkg::*;

  cbs_op_t op_q, op_d;
  logic [2:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic last_q;
  logic [2:0] cyc_q;
  cbs_bus_t bus_q;

  // cycle number about to run; cycle one is the byte after the opcode
  wire logic [2:0] cur_cnt = busy_q ? cnt_q : CBS_CNT_W1; // RQ18
  wire cbs_op_t cur_op = busy_q ? op_q : i_op;
  wire logic active = busy_q || (i_start && i_op != CBS_OP_NONE);

  cbs_kind_t kind;
  cbs_asrc_t asrc;
  cbs_wsrc_t wsrc;
  logic fetch;
  logic [2:0] total;

  // per-instruction cycle table
  always_comb begin
    kind = CBS_KIND_READ;
    asrc = CBS_AS_PC;
    wsrc = CBS_WD_NONE;
    total = CBS_CNT_W1;
    case (cur_op)
      CBS_OP_LD16_DIR: begin
        total = CBS_STEP4; // RQ5
        if (cur_cnt == CBS_STEP2) asrc = CBS_AS_EA; // RQ5
        if (cur_cnt == CBS_STEP3) asrc = CBS_AS_EA1; // RQ5
      end
      CBS_OP_LD16_IDX: begin
        total = CBS_STEP5; // RQ5
        if (cur_cnt == CBS_STEP2) kind = CBS_KIND_DUMMY;
        if (cur_cnt == CBS_STEP3) asrc = CBS_AS_EA; // RQ5
        if (cur_cnt == CBS_STEP4) asrc = CBS_AS_EA1; // RQ5
      end
      CBS_OP_LD16_EXT: begin
        total = CBS_STEP5; // RQ5
        if (cur_cnt == CBS_STEP3) asrc = CBS_AS_EA; // RQ5
        if (cur_cnt == CBS_STEP4) asrc = CBS_AS_EA1; // RQ5
      end
      CBS_OP_ST16_DIR: begin
        total = CBS_STEP4; // RQ6
        if (cur_cnt == CBS_STEP2) begin
          kind = CBS_KIND_WRITE;
          asrc = CBS_AS_EA;
          wsrc = CBS_WD_HI; // RQ6
        end
        if (cur_cnt == CBS_STEP3) begin
          kind = CBS_KIND_WRITE;
          asrc = CBS_AS_EA1;
          wsrc = CBS_WD_LO; // RQ6
        end
      end
      CBS_OP_ST16_IDX: begin
        total = CBS_STEP5; // RQ6
        if (cur_cnt == CBS_STEP2) kind = CBS_KIND_DUMMY;
        if (cur_cnt == CBS_STEP3) begin
          kind = CBS_KIND_WRITE;
          asrc = CBS_AS_EA;
          wsrc = CBS_WD_HI; // RQ6
        end
        if (cur_cnt == CBS_STEP4) begin
          kind = CBS_KIND_WRITE;
          asrc = CBS_AS_EA1;
          wsrc = CBS_WD_LO; // RQ6
        end
      end
      CBS_OP_ST16_EXT: begin
        total = CBS_STEP5; // RQ6
        if (cur_cnt == CBS_STEP3) begin
          kind = CBS_KIND_WRITE;
          asrc = CBS_AS_EA;
          wsrc = CBS_WD_HI; // RQ6
        end
        if (cur_cnt == CBS_STEP4) begin
          kind = CBS_KIND_WRITE;
          asrc = CBS_AS_EA1;
          wsrc = CBS_WD_LO; // RQ6
        end
      end
      CBS_OP_JSR_DIR: begin
        total = CBS_STEP5; // RQ7
        if (cur_cnt == CBS_STEP2) kind = CBS_KIND_DUMMY;
        if (cur_cnt == CBS_STEP3) begin
          kind = CBS_KIND_WRITE;
          asrc = CBS_AS_SP;
          wsrc = CBS_WD_RET_LO; // RQ7
        end
        if (cur_cnt == CBS_STEP4) begin
          kind = CBS_KIND_WRITE;
          asrc = CBS_AS_SPM1;
          wsrc = CBS_WD_RET_HI; // RQ7
        end
        if (cur_cnt == CBS_STEP5) asrc = CBS_AS_EA;
      end
      CBS_OP_JSR_IDX: begin
        total = CBS_STEP5; // RQ7
        if (cur_cnt == CBS_STEP2) kind = CBS_KIND_DUMMY;
        if (cur_cnt == CBS_STEP3) begin
          kind = CBS_KIND_WRITE;
          asrc = CBS_AS_SP;
          wsrc = CBS_WD_RET_LO; // RQ7
        end
        if (cur_cnt == CBS_STEP4) begin
          kind = CBS_KIND_WRITE;
          asrc = CBS_AS_SPM1;
          wsrc = CBS_WD_RET_HI; // RQ7
        end
        if (cur_cnt == CBS_STEP5) asrc = CBS_AS_EA;
      end
      CBS_OP_JSR_EXT: begin
        total = CBS_STEP6; // RQ13
        if (cur_cnt == CBS_STEP3) kind = CBS_KIND_DUMMY;
        if (cur_cnt == CBS_STEP4) begin
          kind = CBS_KIND_WRITE;
          asrc = CBS_AS_SP;
          wsrc = CBS_WD_RET_LO; // RQ13
        end
        if (cur_cnt == CBS_STEP5) begin
          kind = CBS_KIND_WRITE;
          asrc = CBS_AS_SPM1;
          wsrc = CBS_WD_RET_HI; // RQ13
        end
        if (cur_cnt == CBS_STEP6) asrc = CBS_AS_EA;
      end
      CBS_OP_JMP_IDX: begin
        total = CBS_STEP3; // RQ9
        if (cur_cnt == CBS_STEP2) kind = CBS_KIND_DUMMY;
        if (cur_cnt == CBS_STEP3) asrc = CBS_AS_EA; // RQ9
      end
      CBS_OP_TIM_DIR: begin
        total = CBS_STEP4; // RQ8
        if (cur_cnt == CBS_STEP3) asrc = CBS_AS_EA;
      end
      CBS_OP_TIM_IDX: begin
        total = CBS_STEP5; // RQ12
        if (cur_cnt == CBS_STEP3) kind = CBS_KIND_DUMMY;
        if (cur_cnt == CBS_STEP4) asrc = CBS_AS_EA;
      end
      CBS_OP_LOGIC_DIR, CBS_OP_LOGIC_IDX, CBS_OP_RMW_IDX, CBS_OP_RMW_EXT: begin
        total = (cur_op == CBS_OP_LOGIC_IDX) ? CBS_STEP7 : CBS_STEP6; // RQ8 RQ10 RQ12
        if (cur_op inside {CBS_OP_LOGIC_IDX, CBS_OP_RMW_IDX} && cur_cnt == total - CBS_STEP4) kind = CBS_KIND_DUMMY;
        if (cur_cnt == total - CBS_STEP3) asrc = CBS_AS_EA;
        if (cur_cnt == total - CBS_STEP2) kind = CBS_KIND_DUMMY; // RQ10
        if (cur_cnt == total - CBS_CNT_W1) begin
          kind = CBS_KIND_WRITE;
          asrc = CBS_AS_EA;
          wsrc = CBS_WD_RES; // RQ10
        end
      end
      CBS_OP_ZERO_IDX: begin
        total = CBS_STEP5; // RQ11
        if (cur_cnt == CBS_STEP2) kind = CBS_KIND_DUMMY;
        if (cur_cnt == CBS_STEP3) asrc = CBS_AS_EA;
        if (cur_cnt == CBS_STEP4) begin
          kind = CBS_KIND_WRITE;
          asrc = CBS_AS_EA;
          wsrc = CBS_WD_ZERO; // RQ11
        end
      end
      CBS_OP_ZERO_EXT: begin
        total = CBS_STEP5; // RQ11
        if (cur_cnt == CBS_STEP3) asrc = CBS_AS_EA;
        if (cur_cnt == CBS_STEP4) begin
          kind = CBS_KIND_WRITE;
          asrc = CBS_AS_EA;
          wsrc = CBS_WD_ZERO; // RQ11
        end
      end
      CBS_OP_POP_X: begin
        total = CBS_STEP4; // RQ14
        if (cur_cnt == CBS_STEP2) kind = CBS_KIND_DUMMY;
        if (cur_cnt == CBS_STEP3) asrc = CBS_AS_SPP1;
        if (cur_cnt == CBS_STEP4) asrc = CBS_AS_SPP2;
      end
      CBS_OP_PUSH_ACC: begin
        total = CBS_STEP4; // RQ15
        if (cur_cnt == CBS_STEP2) kind = CBS_KIND_DUMMY;
        if (cur_cnt == CBS_STEP3) begin
          kind = CBS_KIND_WRITE;
          asrc = CBS_AS_SP;
          wsrc = CBS_WD_LO; // RQ15
        end
      end
      CBS_OP_DAA_SWAP_DOUBLE_WITH_INDEX: begin
        total = CBS_STEP2; // RQ16
        if (cur_cnt == CBS_STEP2) kind = CBS_KIND_DUMMY;
      end
      default: begin
        total = CBS_CNT_W1;
      end
    endcase
  end

  // prefetching groups fetch in cycle one, others in their last cycle
  wire logic prefetch_op = cur_op inside {CBS_OP_POP_X, CBS_OP_DAA_SWAP_DOUBLE_WITH_INDEX}; // RQ17
  wire logic is_final = (cur_cnt == total);
  always_comb begin
    fetch = prefetch_op ? (cur_cnt == CBS_CNT_W1) : is_final; // RQ4 RQ14 RQ16
  end

  logic [15:0] addr_sel;
  always_comb begin
    case (asrc)
      CBS_AS_DUMMY: addr_sel = CBS_DUMMY_ADDR;
      CBS_AS_EA: addr_sel = i_ctx.eff_addr;
      CBS_AS_EA1: addr_sel = i_ctx.eff_addr + CBS_ADDR_NEXT; // RQ5 RQ6
      CBS_AS_SP: addr_sel = i_ctx.stack_ptr;
      CBS_AS_SPM1: addr_sel = i_ctx.stack_ptr - CBS_ADDR_NEXT; // RQ7
      CBS_AS_SPP1: addr_sel = i_ctx.stack_ptr + CBS_ADDR_NEXT; // RQ14
      CBS_AS_SPP2: addr_sel = i_ctx.stack_ptr + CBS_ADDR_SKIP2; // RQ14
      default: addr_sel = i_ctx.pc_next;
    endcase
  end

  logic [7:0] wd_sel;
  always_comb begin
    case (wsrc)
      CBS_WD_HI: wd_sel = i_ctx.wdata16[15:8];
      CBS_WD_LO: wd_sel = i_ctx.wdata16[7:0];
      CBS_WD_RES: wd_sel = i_ctx.result;
      CBS_WD_ZERO: wd_sel = CBS_ZERO_BYTE; // RQ11
      CBS_WD_RET_LO: wd_sel = i_ctx.ret_addr[7:0];
      CBS_WD_RET_HI: wd_sel = i_ctx.ret_addr[15:8];
      default: wd_sel = CBS_ZERO_BYTE;
    endcase
  end

  cbs_bus_t bus_d;
  always_comb begin
    bus_d = '{addr: CBS_DUMMY_ADDR, wdata: CBS_ZERO_BYTE, data_oe_n: 1'b1,
              rw: 1'b1, rd_n: 1'b1, wr_n: 1'b1, opcode_fetch_strobe_n: 1'b1};
    if (active) begin
      case (kind)
        CBS_KIND_READ: begin
          bus_d.addr = addr_sel;
          bus_d.rd_n = 1'b0; // RQ1
          bus_d.opcode_fetch_strobe_n = ~fetch; // RQ4
        end
        CBS_KIND_WRITE: begin
          bus_d.addr = addr_sel;
          bus_d.wdata = wd_sel;
          bus_d.data_oe_n = 1'b0;
          bus_d.rw = 1'b0; // RQ2
          bus_d.wr_n = 1'b0; // RQ2
        end
        default: begin
          bus_d.addr = CBS_DUMMY_ADDR; // RQ3
        end
      endcase
    end
  end

  always_comb begin
    op_d = cur_op;
    cnt_d = cur_cnt + CBS_CNT_W1;
    busy_d = active && !is_final;
    if (!active) begin
      op_d = CBS_OP_NONE;
      cnt_d = CBS_CNT_W1;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      op_q <= CBS_OP_NONE;
      cnt_q <= CBS_CNT_W1;
      busy_q <= 1'b0;
      last_q <= 1'b0;
      cyc_q <= CBS_CYC_IDLE;
      bus_q <= '{addr: CBS_DUMMY_ADDR, wdata: CBS_ZERO_BYTE, data_oe_n: 1'b1,
                 rw: 1'b1, rd_n: 1'b1, wr_n: 1'b1, opcode_fetch_strobe_n: 1'b1};
    end else begin
      op_q <= op_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      last_q <= active && is_final;
      cyc_q <= active ? cur_cnt : CBS_CYC_IDLE;
      bus_q <= bus_d;
    end
  end

  assign o_busy = busy_q;
  assign o_last = last_q;
  assign o_cycle = cyc_q;
  assign o_bus = bus_q;
endmodule : cbs_cpu_bus_cycle_sequencer
`default_nettype wire

// ---- verification/cbs_cpu_bus_cycle_sequencer_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module cbs_cpu_bus_cycle_sequencer_tb_top;
  import cbs_pkg::*;
  typedef struct packed {
    cbs_op_t op;
    logic [2:0] n;
    logic [27:0] seq;
  } cbs_row_t;
  // one nibble per cycle: write flag, address source
  localparam cbs_row_t ROWS [21] = '{'{CBS_OP_LD16_DIR, 3'h4, 28'h320}, '{CBS_OP_LD16_IDX, 3'h5, 28'h3210},
    '{CBS_OP_LD16_EXT, 3'h5, 28'h3200}, '{CBS_OP_ST16_DIR, 3'h4, 28'hBA0}, '{CBS_OP_ST16_IDX, 3'h5, 28'hBA10},
    '{CBS_OP_ST16_EXT, 3'h5, 28'hBA00}, '{CBS_OP_JSR_DIR, 3'h5, 28'h2DC10}, '{CBS_OP_JSR_IDX, 3'h5, 28'h2DC10},
    '{CBS_OP_JSR_EXT, 3'h6, 28'h2DC100}, '{CBS_OP_JMP_IDX, 3'h3, 28'h210}, '{CBS_OP_TIM_DIR, 3'h4, 28'h200},
    '{CBS_OP_TIM_IDX, 3'h5, 28'h2100}, '{CBS_OP_LOGIC_DIR, 3'h6, 28'hA1200}, '{CBS_OP_LOGIC_IDX, 3'h7, 28'hA12100},
    '{CBS_OP_RMW_IDX, 3'h6, 28'hA1210}, '{CBS_OP_RMW_EXT, 3'h6, 28'hA1200}, '{CBS_OP_ZERO_IDX, 3'h5, 28'hA210},
    '{CBS_OP_ZERO_EXT, 3'h5, 28'hA200}, '{CBS_OP_POP_X, 3'h4, 28'h7610}, '{CBS_OP_PUSH_ACC, 3'h4, 28'hC10},
    '{CBS_OP_DAA_SWAP_DOUBLE_WITH_INDEX, 3'h2, 28'h10}};
  localparam logic [15:0] ADDR_OF [8] = '{16'h1000, 16'hFFFF, 16'h2000, 16'h2001, 16'h3000, 16'h2FFF, 16'h3001,
    16'h3002};
  localparam logic [25:0] IDLE = {16'hFFFF, 4'hF, 1'b1, 1'b0, 1'b0, 3'h0};
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_start = 1'b0;
  cbs_op_t i_op = CBS_OP_NONE;
  cbs_ctx_t i_ctx = '{16'h1000, 16'h2000, 16'h3000, 16'h4321, 16'hA55A, 8'h3C};
  logic o_busy;
  logic o_last;
  logic [2:0] o_cycle;
  cbs_bus_t o_bus;
  int err_count = 0;
  int n_checks = 0;
  always #4 i_core_clk = ~i_core_clk;
  cbs_cpu_bus_cycle_sequencer u_cbs_cpu_bus_cycle_sequencer (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_start(i_start), .i_op(i_op), .i_ctx(i_ctx), .o_busy(o_busy), .o_last(o_last), .o_cycle(o_cycle), .o_bus(o_bus));
  cbs_mem_model u_cbs_mem_model (.i_core_clk(i_core_clk), .i_bus(o_bus));
  wire logic [25:0] got = {o_bus.addr, o_bus.rw, o_bus.rd_n, o_bus.wr_n, o_bus.data_oe_n,
    o_bus.opcode_fetch_strobe_n, o_last, o_busy, o_cycle};
  task automatic chk(input logic [25:0] g, input logic [25:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  // entered at a falling edge; returns at the falling edge of the last cycle
  task automatic run(input int i);
    logic [3:0] c;
    logic f;
    int t;
    i_op = ROWS[i].op;
    i_start = 1'b1;
    t = 0;
    do begin
      @(posedge i_core_clk);
      #1;
      t++;
    end while (o_cycle !== 3'h1 && t < 4);
    for (int k = 1; k <= ROWS[i].n; k++) begin
      if (k > 1) begin
        @(posedge i_core_clk);
        #1;
      end
      c = ROWS[i].seq[4*k-4 +: 4];
      f = (ROWS[i].op inside {CBS_OP_POP_X, CBS_OP_DAA_SWAP_DOUBLE_WITH_INDEX}) ? (k == 1) : (k == ROWS[i].n);
      chk(got, {ADDR_OF[c[2:0]], (c[2:0] == 3'h1) ? 4'hF : c[3] ? 4'h4 : 4'hB, !f, k == ROWS[i].n,
        k < ROWS[i].n, k[2:0]});
      @(negedge i_core_clk);
      if (k == 1) i_start = 1'b0;
    end
  endtask : run
  initial begin
    repeat (3) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_rst = 1'b0;
    #1;
    chk(got, IDLE);
    @(negedge i_core_clk);
    for (int i = 0; i < 21; i++) run(i);
    run(5);
    chk({10'h0, u_cbs_mem_model.mem[16'h2000], u_cbs_mem_model.mem[16'h2001]}, 26'hA55A);
    run(17);
    chk({18'h0, u_cbs_mem_model.mem[16'h2000]}, 26'h0);
    run(12);
    chk({18'h0, u_cbs_mem_model.mem[16'h2000]}, 26'h3C);
    run(8);
    chk({10'h0, u_cbs_mem_model.mem[16'h2FFF], u_cbs_mem_model.mem[16'h3000]}, 26'h4321);
    run(19);
    chk({18'h0, u_cbs_mem_model.mem[16'h3000]}, 26'h5A);
    i_op = CBS_OP_LOGIC_IDX;
    i_start = 1'b1;
    repeat (3) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_rst = 1'b1;
    i_start = 1'b0;
    #1;
    chk(got, IDLE);
    @(negedge i_core_clk);
    i_rst = 1'b0;
    run(9);
    stop_test();
  end
  initial begin
    #50000;
    err_count++;
    stop_test();
  end
endmodule : cbs_cpu_bus_cycle_sequencer_tb_top
bind cbs_cpu_bus_cycle_sequencer cbs_seq_sva u_cbs_seq_sva (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_start(i_start), .i_op(i_op), .i_ctx(i_ctx), .o_busy(o_busy), .o_last(o_last), .o_cycle(o_cycle), .o_bus(o_bus));
`default_nettype wire

// ---- verification/cbs_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cbs_mem_model (
  input wire logic i_core_clk,
  input wire cbs_pkg::cbs_bus_t i_bus
);
  import cbs_pkg::*;
  logic [7:0] mem [65536];
  // a byte lands only when strobe and direction agree
  always @(posedge i_core_clk) begin
    if (!i_bus.wr_n && !i_bus.rw) begin
      mem[i_bus.addr] <= i_bus.wdata;
    end
  end
endmodule : cbs_mem_model
`default_nettype wire

// ---- verification/cbs_seq_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module cbs_seq_sva (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire cbs_pkg::cbs_op_t i_op,
  input wire cbs_pkg::cbs_ctx_t i_ctx,
  input wire logic o_busy,
  input wire logic o_last,
  input wire logic [2:0] o_cycle,
  input wire cbs_pkg::cbs_bus_t o_bus
);
  import cbs_pkg::*;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire cbs_bus_t b = o_bus;
  sequence s_jmp;
    b.addr == CBS_DUMMY_ADDR ##1 !b.rd_n && !b.opcode_fetch_strobe_n && o_last && b.addr == i_ctx.eff_addr;
  endsequence
  sequence s_rmw;
    !b.rd_n ##1 b.rd_n && b.wr_n ##1 !b.wr_n && b.wdata == i_ctx.result && b.addr == i_ctx.eff_addr;
  endsequence
  chk_read_strobes: assert property (!b.rd_n |-> b.rw && b.wr_n && b.data_oe_n)
    else $error("bad read strobes");
  chk_write_strobes: assert property (!b.wr_n |-> !b.rw && b.rd_n && !b.data_oe_n)
    else $error("bad write strobes");
  chk_dummy_addr: assert property (b.rd_n && b.wr_n |-> b.addr == CBS_DUMMY_ADDR && b.rw && b.opcode_fetch_strobe_n)
    else $error("bad dummy cycle");
  chk_fetch_place: assert property (!b.opcode_fetch_strobe_n |-> !b.rd_n && (o_last || o_cycle == CBS_CNT_W1))
    else $error("fetch strobe misplaced");
  chk_cycle_step: assert property (o_busy |=> o_cycle == $past(o_cycle) + 3'h1)
    else $error("cycle count skipped");
  chk_start_cycle: assert property (!o_busy && i_start && i_op != CBS_OP_NONE |=> o_cycle == CBS_CNT_W1)
    else $error("start not taken");
  chk_jump_seq: assert property (o_busy && i_op == CBS_OP_JMP_IDX && o_cycle == 3'h1 |=> s_jmp)
    else $error("indexed jump order wrong");
  chk_rmw_seq: assert property (o_busy && i_op == CBS_OP_RMW_EXT && o_cycle == 3'h3 |-> s_rmw)
    else $error("modify write order wrong");
  chk_zero_write: assert property (o_busy && i_op == CBS_OP_ZERO_IDX && o_cycle == 3'h3 |=>
    !b.wr_n && b.wdata == CBS_ZERO_BYTE && b.addr == $past(b.addr))
    else $error("zero write wrong");
  chk_pop_reads: assert property (o_busy && i_op == CBS_OP_POP_X && o_cycle == 3'h2 |=>
    b.addr == i_ctx.stack_ptr + 16'h0001 ##1 b.addr == i_ctx.stack_ptr + 16'h0002 && o_last)
    else $error("pop reads wrong");
endmodule : cbs_seq_sva
`default_nettype wire
